// file: rtl/psp_pkg.sv
// Constants shared by the pump serial port setup block.
// Assumes a single 20 MHz system clock.
package psp_pkg;
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          NUM_PORTS       = 3;
   localparam int          PORT_PRI        = 0;
   localparam int          PORT_SEC        = 1;
   localparam int          PORT_ACC        = 2;
   // Line settings after reset
   localparam int          BAUD_DEF        = 9600;
   localparam logic [15:0] BIT_DIV_DEF     = 16'(CLK_HZ / BAUD_DEF);
   localparam logic        EIGHT_BITS_DEF  = 1'b1;
   localparam logic        TWO_STOP_DEF    = 1'b0;
   localparam logic        PARITY_EN_DEF   = 1'b0;
   localparam logic        PARITY_ODD_DEF  = 1'b0;
   // Multidrop addressing
   localparam logic [6:0]  NODE_ID_DEF     = 7'h01;
   localparam int          MAX_NODES       = 32;
   // Response hold-off, least time, rounded up
   localparam int          RESP_DELAY_MS   = 5;
   localparam int          RESP_DELAY_CYC  = (CLK_HZ / 1000) * RESP_DELAY_MS;
   // Loss-of-communication watchdog
   localparam int          MINUTE_S        = 60;
   localparam int          MINUTE_CYC      = CLK_HZ * MINUTE_S;
   localparam logic [8:0]  TIMEOUT_DEF_MIN = 9'h001;
   localparam logic [8:0]  TIMEOUT_MAX_MIN = 9'h1F4;
   // Operation command source
   typedef enum logic [1:0] {
      SRC_PARALLEL  = 2'h0,
      SRC_PRIMARY   = 2'h1,
      SRC_SECONDARY = 2'h2,
      SRC_ACCESSORY = 2'h3
   } psp_src_type;
   // Driver type of the RS485 capable ports
   typedef enum logic {
      DRV_SINGLE = 1'b0,
      DRV_MULTI  = 1'b1
   } psp_drv_type;
   localparam psp_src_type SRC_DEF         = SRC_PARALLEL;
   localparam psp_drv_type DRV_DEF         = DRV_SINGLE;
   // Serial engine states, Gray along the frame
   typedef enum logic [1:0] {
      SER_IDLE  = 2'b00,
      SER_START = 2'b01,
      SER_DATA  = 2'b11,
      SER_STOP  = 2'b10
   } psp_ser_type;
endpackage

// file: rtl/psp_serial_port_setup.sv
// Serial interface of a vacuum pump controller: three serial ports,
// line and driver settings, multidrop id, operation source choice and
// loss-of-communication watchdog.
// Assumes framing and command decode sit outside and report per port.
//
// Operation
// - Three serial ports: primary, secondary, accessory.
// - Primary port works as RS232 or RS485 on one connector.
// - Secondary port works as RS485 only.
// - Driver type for primary and secondary ports: single-point or multi-point.
// - Multidrop node id 1 to 127, default 1, multidrop only.
// - At most 32 interface modules plus one host per bus.
// - Response starts no sooner than 5 ms after a received command.
// - Port choice contacts closed force parallel source, refuse serial operation.
// - Operation source: parallel, primary, secondary or accessory; default parallel.
// - Non-operation commands accepted on every port.
// - Running pump with silent source port gets failure and stop.
// - Timeout 0 to 500 minutes in one-minute steps.
// - Timeout zero disables the watchdog.
// - One timeout for all ports, default one minute.
// - Fieldbus option fitted disables secondary serial port.
`timescale 1ns/10ps
module psp_serial_port_setup #(
   parameter int RESP_DELAY_CYCLES = psp_pkg::RESP_DELAY_CYC,
   parameter int MINUTE_CYCLES     = psp_pkg::MINUTE_CYC
) (
   input  wire logic                    clk_sys,
   input  wire logic                    reset,
   // Line pins, index 0 primary, 1 secondary, 2 accessory
   input  wire logic [2:0]              rxd,
   output logic      [2:0]              txd,
   output logic      [2:0]              tx_drive_oe,
   // Settings, taken on cfg_load
   input  wire logic                    cfg_load,
   input  wire logic [15:0]             cfg_bit_div,
   input  wire logic                    cfg_eight_bits,
   input  wire logic                    cfg_two_stop,
   input  wire logic                    cfg_parity_en,
   input  wire logic                    cfg_parity_odd,
   input  wire logic                    cfg_primary_rs232,
   input  wire psp_pkg::psp_drv_type    cfg_primary_drv,
   input  wire psp_pkg::psp_drv_type    cfg_secondary_drv,
   input  wire logic [6:0]              cfg_node_id,
   input  wire psp_pkg::psp_src_type    cfg_op_source,
   input  wire logic [8:0]              cfg_timeout_min,
   // Straps and pump state
   input  wire logic                    port_choice_closed,
   input  wire logic                    fieldbus_fitted,
   input  wire logic                    pump_running,
   input  wire logic                    comm_fail_clear,
   // Received characters
   output logic      [23:0]             rx_data,
   output logic      [2:0]              rx_valid,
   output logic      [2:0]              rx_error,
   // Command report and gating
   input  wire logic [2:0]              cmd_done,
   input  wire logic                    cmd_is_operation,
   output logic      [2:0]              cmd_accept,
   // Response characters
   input  wire logic [23:0]             tx_data,
   input  wire logic [2:0]              tx_valid,
   output logic      [2:0]              tx_ready,
   // Status
   output psp_pkg::psp_src_type         op_source_active,
   output logic      [2:0]              multidrop_en,
   output logic      [6:0]              multidrop_node_id,
   output logic                         comm_fail,
   output logic                         pump_stop_req
);
   import psp_pkg::*;

   // Elaboration checks
   if (RESP_DELAY_CYCLES < 1 || MINUTE_CYCLES < 1) begin : g_bad_cfg
      $error("psp_serial_port_setup: cycle counts must be at least one");
   end

   logic [15:0]  bit_div_ff;
   logic         eight_bits_ff;
   logic         two_stop_ff;
   logic         parity_en_ff;
   logic         parity_odd_ff;
   logic         primary_rs232_ff;
   psp_drv_type  primary_drv_ff;
   psp_drv_type  secondary_drv_ff;
   logic [6:0]   node_id_ff;
   psp_src_type  op_source_ff;
   logic [8:0]   timeout_ff;
   logic [31:0]  tick_cnt_ff;
   logic [8:0]   minutes_ff;
   logic         comm_fail_ff;
   logic [2:0]   port_on;
   logic [2:0]   rx_line;
   logic [2:0]   tx_busy;
   logic [2:0]   tx_line;
   logic [2:0]   hold_off;
   logic [2:0]   src_hot;
   logic         serial_src;
   logic         wd_active;
   logic         activity;
   logic         minute_tick;
   logic         expired;
   logic [6:0]   nxt_node_id;
   logic [8:0]   nxt_timeout;

   // Settings take their documented defaults from reset
   assign nxt_node_id = (cfg_node_id == 7'h00) ? NODE_ID_DEF : cfg_node_id;
   assign nxt_timeout = (cfg_timeout_min > TIMEOUT_MAX_MIN) ?
                        TIMEOUT_MAX_MIN : cfg_timeout_min;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bit_div_ff       <= BIT_DIV_DEF;
         eight_bits_ff    <= EIGHT_BITS_DEF;
         two_stop_ff      <= TWO_STOP_DEF;
         parity_en_ff     <= PARITY_EN_DEF;
         parity_odd_ff    <= PARITY_ODD_DEF;
         primary_rs232_ff <= 1'b0;
         primary_drv_ff   <= DRV_DEF;
         secondary_drv_ff <= DRV_DEF;
         node_id_ff       <= NODE_ID_DEF;
         op_source_ff     <= SRC_DEF;
         timeout_ff       <= TIMEOUT_DEF_MIN;
      end else if (cfg_load) begin
         bit_div_ff       <= (cfg_bit_div < 16'h0002) ? 16'h0002 : cfg_bit_div;
         eight_bits_ff    <= cfg_eight_bits;
         two_stop_ff      <= cfg_two_stop;
         parity_en_ff     <= cfg_parity_en;
         parity_odd_ff    <= cfg_parity_odd;
         primary_rs232_ff <= cfg_primary_rs232;
         primary_drv_ff   <= cfg_primary_drv;
         secondary_drv_ff <= cfg_secondary_drv;
         node_id_ff       <= nxt_node_id;
         op_source_ff     <= cfg_op_source;
         timeout_ff       <= nxt_timeout;
      end
   end

   // Port availability; fieldbus option takes the secondary connector
   assign port_on = {1'b1, ~fieldbus_fitted, 1'b1};

   // Multidrop only where the driver type asks for it; accessory never, primary even in RS232 mode
   assign multidrop_en      = {1'b0,
                               secondary_drv_ff == DRV_MULTI,
                               primary_drv_ff == DRV_MULTI};
   assign multidrop_node_id = node_id_ff;

   // Source choice with parallel override
   assign op_source_active = port_choice_closed ? SRC_PARALLEL : op_source_ff;
   assign serial_src       = (op_source_active != SRC_PARALLEL);
   assign src_hot          = {op_source_active == SRC_ACCESSORY,
                              op_source_active == SRC_SECONDARY,
                              op_source_active == SRC_PRIMARY};

   // Per-port engines, hold-off and gating
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [31:0] delay_ff;
      logic [7:0]  rx_byte;
      logic        rx_ok;
      logic        rx_bad;

      psp_uart_rx u_rx (
         .clk_sys    (clk_sys),
         .reset      (reset),
         .rxd        (rx_line[p]),
         .bit_div    (bit_div_ff),
         .eight_bits (eight_bits_ff),
         .parity_en  (parity_en_ff),
         .parity_odd (parity_odd_ff),
         .data_ff    (rx_byte),
         .valid_ff   (rx_ok),
         .err_ff     (rx_bad)
      );

      psp_uart_tx u_tx (
         .clk_sys    (clk_sys),
         .reset      (reset),
         .data       (tx_data[8*p +: 8]),
         .valid      (tx_valid[p] & ~hold_off[p] & port_on[p]),
         .ready      (),
         .bit_div    (bit_div_ff),
         .eight_bits (eight_bits_ff),
         .two_stop   (two_stop_ff),
         .parity_en  (parity_en_ff),
         .parity_odd (parity_odd_ff),
         .txd_ff     (tx_line[p]),
         .busy_ff    (tx_busy[p])
      );

      // Disabled port sees an idle line
      assign rx_line[p]          = rxd[p] | ~port_on[p];
      assign rx_data[8*p +: 8]   = rx_byte;
      assign rx_valid[p]         = rx_ok;
      assign rx_error[p]         = rx_bad;
      assign txd[p]              = tx_line[p];
      assign hold_off[p]         = (delay_ff != 32'h0000_0000);
      assign tx_ready[p]         = ~tx_busy[p] & ~hold_off[p] & port_on[p];

      // Operation commands only from the active source port
      assign cmd_accept[p] = cmd_done[p] & port_on[p] &
                             (~cmd_is_operation | src_hot[p]);

      // Response hold-off after each received command
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            delay_ff <= 32'h0000_0000;
         end else if (cmd_done[p]) begin
            delay_ff <= 32'(RESP_DELAY_CYCLES);
         end else if (hold_off[p]) begin
            delay_ff <= delay_ff - 32'h0000_0001;
         end
      end
   end

   // RS485 drivers turn on only while sending; RS232 drives always
   assign tx_drive_oe = {1'b1,
                         tx_busy[PORT_SEC] & port_on[PORT_SEC],
                         primary_rs232_ff | tx_busy[PORT_PRI]};

   // Watchdog runs only with a serial source, a running pump, nonzero time
   assign wd_active   = pump_running & serial_src &
                        (timeout_ff != 9'h000);
   assign activity    = |(rx_valid & src_hot);
   assign minute_tick = (tick_cnt_ff == 32'(MINUTE_CYCLES - 1));
   assign expired     = wd_active & (minutes_ff >= timeout_ff);

   // Minute prescaler and minute count, restarted on traffic
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tick_cnt_ff <= 32'h0000_0000;
         minutes_ff  <= 9'h000;
      end else if (!wd_active || activity) begin
         tick_cnt_ff <= 32'h0000_0000;
         minutes_ff  <= 9'h000;
      end else if (minute_tick) begin
         tick_cnt_ff <= 32'h0000_0000;
         if (minutes_ff != TIMEOUT_MAX_MIN) begin
            minutes_ff <= minutes_ff + 9'h001;
         end
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      end
   end

   // Sticky failure; a new expiry wins over a clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         comm_fail_ff <= 1'b0;
      end else if (expired) begin
         comm_fail_ff <= 1'b1;
      end else if (comm_fail_clear) begin
         comm_fail_ff <= 1'b0;
      end
   end

   assign comm_fail     = comm_fail_ff;
   assign pump_stop_req = comm_fail_ff;
endmodule

// file: rtl/psp_uart_rx.sv
// Asynchronous serial character receiver, one per port.
// Assumes rxd is synchronous to clk_sys and idles high.
`timescale 1ns/10ps
module psp_uart_rx (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        rxd,
   input  wire logic [15:0] bit_div,
   input  wire logic        eight_bits,
   input  wire logic        parity_en,
   input  wire logic        parity_odd,
   output logic      [7:0]  data_ff,
   output logic             valid_ff,
   output logic             err_ff
);
   import psp_pkg::*;

   psp_ser_type state_ff;
   psp_ser_type nxt_state;
   logic [15:0] cnt_ff;
   logic [3:0]  bit_ff;
   logic [8:0]  shf_ff;
   logic        tick;
   logic [3:0]  nbits;
   logic [7:0]  dword;
   logic        par_bad;

   // Bit timing: half bit for start, full bits after
   assign tick    = (cnt_ff == 16'h0000);
   assign nbits   = 4'(eight_bits ? 8 : 7) + 4'(parity_en);
   assign dword   = eight_bits ? shf_ff[7:0] : {1'b0, shf_ff[6:0]};
   assign par_bad = parity_en &
                    ((^dword) ^ (eight_bits ? shf_ff[8] : shf_ff[7]) ^ parity_odd);

   // Frame sequencing, LSB first
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SER_IDLE:  if (!rxd) nxt_state = SER_START;
         SER_START: if (tick) nxt_state = rxd ? SER_IDLE : SER_DATA;
         SER_DATA:  if (tick && bit_ff == nbits - 4'h1) nxt_state = SER_STOP;
         SER_STOP:  if (tick) nxt_state = SER_IDLE;
      endcase
   end

   // Counters, shifter and result strobes
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_ff <= SER_IDLE;
         cnt_ff   <= 16'h0000;
         bit_ff   <= 4'h0;
         shf_ff   <= 9'h000;
         data_ff  <= 8'h00;
         valid_ff <= 1'b0;
         err_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         valid_ff <= 1'b0;
         err_ff   <= 1'b0;
         if (state_ff == SER_IDLE) begin
            cnt_ff <= {1'b0, bit_div[15:1]};
            bit_ff <= 4'h0;
         end else if (tick) begin
            cnt_ff <= bit_div - 16'h0001;
         end else begin
            cnt_ff <= cnt_ff - 16'h0001;
         end
         if (state_ff == SER_DATA && tick) begin
            shf_ff[bit_ff] <= rxd;
            bit_ff         <= bit_ff + 4'h1;
         end
         if (state_ff == SER_STOP && tick) begin
            data_ff  <= dword;
            valid_ff <= rxd & ~par_bad;
            err_ff   <= ~rxd | par_bad;
         end
      end
   end
endmodule

// file: rtl/psp_uart_tx.sv
// Asynchronous serial character transmitter, one per port.
// Assumes the caller holds data while valid and ready are both high.
`timescale 1ns/10ps
module psp_uart_tx (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [7:0]  data,
   input  wire logic        valid,
   output logic             ready,
   input  wire logic [15:0] bit_div,
   input  wire logic        eight_bits,
   input  wire logic        two_stop,
   input  wire logic        parity_en,
   input  wire logic        parity_odd,
   output logic             txd_ff,
   output logic             busy_ff
);
   import psp_pkg::*;

   logic [11:0] frame_ff;
   logic [15:0] cnt_ff;
   logic [3:0]  left_ff;
   logic [7:0]  dword;
   logic        par;
   logic [11:0] frame;
   logic [3:0]  nbits;

   // Frame built as start, data, parity, stop
   assign ready = ~busy_ff;
   assign dword = eight_bits ? data : {1'b0, data[6:0]};
   assign par   = (^dword) ^ parity_odd;
   assign nbits = 4'(eight_bits ? 8 : 7) + 4'(parity_en) + 4'(two_stop) + 4'h2;
   assign frame = eight_bits ?
                  (parity_en ? {2'b11, par, dword, 1'b0} : {3'b111, dword, 1'b0}) :
                  (parity_en ? {3'b111, par, dword[6:0], 1'b0}
                             : {4'b1111, dword[6:0], 1'b0});

   // Shift one bit per bit time
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         frame_ff <= 12'hFFF;
         cnt_ff   <= 16'h0000;
         left_ff  <= 4'h0;
         txd_ff   <= 1'b1;
         busy_ff  <= 1'b0;
      end else if (!busy_ff) begin
         if (valid) begin
            frame_ff <= frame;
            left_ff  <= nbits;
            cnt_ff   <= 16'h0000;
            busy_ff  <= 1'b1;
         end
      end else if (cnt_ff == 16'h0000) begin
         if (left_ff == 4'h0) begin
            busy_ff <= 1'b0;
            txd_ff  <= 1'b1;
         end else begin
            txd_ff   <= frame_ff[0];
            frame_ff <= {1'b1, frame_ff[11:1]};
            left_ff  <= left_ff - 4'h1;
            cnt_ff   <= bit_div - 16'h0001;
         end
      end else begin
         cnt_ff <= cnt_ff - 16'h0001;
      end
   end
endmodule

// file: verification/psp_host_model.sv
// Host model on the three serial lines.
// Assumes lines idle high and bit times counted in clk_sys cycles.
`timescale 1ns/10ps
module psp_host_model (
   input  wire logic       clk_sys,
   output logic      [2:0] rxd_line,
   input  wire logic [2:0] txd_line
);
   // Lines rest at the idle mark level
   initial rxd_line = 3'h7;
   // Start, eight bits LSB first, even parity only when pe is set, stop, one idle bit
   task automatic send_char(input int p, input logic [7:0] d, input int dv,
                            input logic pe, input logic bad);
      logic [11:0] fr;
      int          n;
      fr = {2'h3, pe ? (^d) ^ bad : 1'h1, d, 1'h0};
      n = pe ? 12 : 11;
      for (int i = 0; i < n; i++) begin
         rxd_line[p] = fr[i];
         repeat (dv) @(posedge clk_sys);
         #1;
      end
   endtask
   // Samples a response mid-bit
   task automatic recv_char(input int p, input int dv, output logic [7:0] d,
                            output logic ok);
      int i;
      d = 8'h00;
      ok = 1'h0;
      for (i = 0; i < 1000 && txd_line[p] !== 1'h0; i++)
         @(posedge clk_sys);
      if (i == 1000)
         return;
      repeat (dv / 2) @(posedge clk_sys);
      for (int b = 0; b < 8; b++) begin
         repeat (dv) @(posedge clk_sys);
         d[b] = txd_line[p];
      end
      repeat (dv) @(posedge clk_sys);
      ok = txd_line[p];
   endtask
endmodule

// file: verification/psp_serial_port_setup_assertions.sv
// Checker bound to the pump serial port setup top.
// Assumes one clock, clk_sys, and an active high asynchronous reset.
`timescale 1ns/10ps
module psp_serial_port_setup_assertions (
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   input  wire logic [2:0]           txd,
   input  wire logic [2:0]           tx_drive_oe,
   input  wire logic                 fieldbus_fitted,
   input  wire logic                 port_choice_closed,
   input  wire logic                 pump_running,
   input  wire logic [2:0]           rx_valid,
   input  wire logic [2:0]           cmd_done,
   input  wire logic                 cmd_is_operation,
   input  wire logic [2:0]           cmd_accept,
   input  wire logic [2:0]           tx_valid,
   input  wire logic [2:0]           tx_ready,
   input  wire psp_pkg::psp_src_type op_source_active,
   input  wire logic [6:0]           multidrop_node_id,
   input  wire logic                 comm_fail,
   input  wire logic                 pump_stop_req
);
   import psp_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Command gating by operation source
   AST_OP_GATE: assert property (cmd_done[0] && cmd_is_operation &&
      op_source_active != SRC_PRIMARY |-> !cmd_accept[0]) else $error("op cmd taken off source");
   AST_OP_SRC: assert property (cmd_done[2] && cmd_is_operation &&
      op_source_active == SRC_ACCESSORY |-> cmd_accept[2]) else $error("op cmd refused on source");
   AST_NON_OP: assert property (cmd_done[0] && !cmd_is_operation
      |-> cmd_accept[0]) else $error("query refused");
   AST_FORCE_PAR: assert property (port_choice_closed
      |-> op_source_active == SRC_PARALLEL) else $error("contacts did not force parallel");
   // Response hold-off and transmit start
   AST_HOLDOFF: assert property (cmd_done[0] |=> !tx_ready[0] [*8])
      else $error("response not held off");
   AST_TX_START: assert property (tx_valid[0] && tx_ready[0] |=> !tx_ready[0] ##1 !txd[0])
      else $error("no start bit after offer");
   AST_FB_OFF: assert property (fieldbus_fitted
      |-> !tx_ready[1] && !cmd_accept[1] && !tx_drive_oe[1]) else $error("secondary port active");
   // Node id range, failure outputs, receive pulse
   AST_NODE_ID: assert property (multidrop_node_id != 7'h00)
      else $error("node id zero");
   AST_STOP_REQ: assert property (pump_stop_req == comm_fail)
      else $error("stop request differs from failure");
   AST_FAIL_RUN: assert property ($rose(comm_fail) |-> $past(pump_running))
      else $error("failure while pump idle");
   AST_RX_PULSE: assert property (rx_valid[0] |=> !rx_valid[0])
      else $error("receive pulse too long");
   // Main scenarios
   cover property (cmd_done[0] && cmd_is_operation && cmd_accept[0]);
   cover property ($rose(comm_fail));
   cover property (tx_valid[2] && tx_ready[2]);
endmodule

bind psp_serial_port_setup psp_serial_port_setup_assertions u_psp_chk (
   .clk_sys, .reset, .txd, .tx_drive_oe, .fieldbus_fitted, .port_choice_closed,
   .pump_running, .rx_valid, .cmd_done, .cmd_is_operation, .cmd_accept, .tx_valid,
   .tx_ready, .op_source_active, .multidrop_node_id, .comm_fail, .pump_stop_req
);

// file: verification/tb_top.sv
// Self-checking bench for the pump serial port setup block.
// Assumes the host model on the lines and the bound checker.
`timescale 1ns/10ps
module tb_top;
   import psp_pkg::*;
   localparam int RESP = 10;
   localparam int MIN  = 100;
   logic        clk_sys = 1'h0, reset = 1'h1, cfg_load = 1'h0, par = 1'h0, cfg_pr = 1'h0;
   logic        port_choice_closed = 1'h0, fieldbus_fitted = 1'h0, pump_running = 1'h0;
   logic        comm_fail_clear = 1'h0, cmd_is_operation = 1'h0, comm_fail, pump_stop_req;
   logic [2:0]  cmd_done = 3'h0, tx_valid = 3'h0, rxd, txd, tx_drive_oe, rx_valid;
   logic [2:0]  rx_error, cmd_accept, tx_ready, multidrop_en;
   logic [23:0] rx_data, tx_data = 24'h00_0000;
   logic [15:0] div = BIT_DIV_DEF;
   logic [6:0]  node = 7'h01, multidrop_node_id;
   logic [8:0]  tmo = 9'h001;
   logic [31:0] seed = 32'h0000_0004;
   psp_drv_type drv0 = DRV_SINGLE, drv1 = DRV_SINGLE;
   psp_src_type src = SRC_PARALLEL, op_source_active;
   logic [7:0]  rx_q[$];
   int          num_errors = 0, check_count = 0, errs = 0, cyc = 0, last_rx = 0;
   // Clock
   always #25 clk_sys = ~clk_sys;
   psp_serial_port_setup #(.RESP_DELAY_CYCLES(RESP), .MINUTE_CYCLES(MIN)) u_dut (
      .clk_sys, .reset, .rxd, .txd, .tx_drive_oe, .cfg_load, .cfg_bit_div(div),
      .cfg_eight_bits(1'h1), .cfg_two_stop(1'h0), .cfg_parity_en(par), .cfg_parity_odd(1'h0),
      .cfg_primary_rs232(cfg_pr), .cfg_primary_drv(drv0), .cfg_secondary_drv(drv1),
      .cfg_node_id(node), .cfg_op_source(src), .cfg_timeout_min(tmo), .port_choice_closed,
      .fieldbus_fitted, .pump_running, .comm_fail_clear, .rx_data, .rx_valid, .rx_error,
      .cmd_done, .cmd_is_operation, .cmd_accept, .tx_data, .tx_valid, .tx_ready,
      .op_source_active, .multidrop_en, .multidrop_node_id, .comm_fail, .pump_stop_req);
   psp_host_model u_host (.clk_sys(clk_sys), .rxd_line(rxd), .txd_line(txd));
   // Logs received characters and errors
   always @(negedge clk_sys) begin
      cyc++;
      for (int p = 0; p < 3; p++) begin
         if (rx_valid[p] === 1'h1) begin
            rx_q.push_back(rx_data[8*p+:8]);
            last_rx = cyc;
         end
         if (rx_error[p] === 1'h1)
            errs++;
      end
   end
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic results;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic fail_out;
      num_errors++;
      results;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic cfg(input logic [15:0] d, input logic pe, input logic [6:0] nd,
                      input psp_src_type s, input logic [8:0] t, input logic [1:0] md,
                      input logic rs);
      div = d;
      par = pe;
      node = nd;
      src = s;
      tmo = t;
      drv0 = psp_drv_type'(md[0]);
      drv1 = psp_drv_type'(md[1]);
      cfg_pr = rs;
      cfg_load = 1'h1;
      tick(1);
      cfg_load = 1'h0;
      tick(1);
   endtask
   // One host character; expected unless bad or port off
   task automatic rx_byte(input int p, input logic [7:0] d, input int dv, input logic bad);
      int e;
      e = errs;
      u_host.send_char(p, d, dv, par, bad);
      tick(2);
      check(rx_q.size(), !(bad || (p == 1 && fieldbus_fitted)));
      check(errs - e, bad);
      while (rx_q.size() > 0)
         check(rx_q.pop_front(), d);
   endtask
   // Hang guard
   initial begin
      repeat (90000) @(posedge clk_sys);
      fail_out;
   end
   // Main sequence
   initial begin
      logic [2:0] ex;
      logic [7:0] d, got;
      logic       ok;
      int         n, eff;
      repeat (5) @(posedge clk_sys);
      #1 reset = 1'h0;
      check(txd, 3'h7);
      check(tx_drive_oe, 3'h4);
      check(op_source_active, SRC_DEF);
      check(multidrop_node_id, NODE_ID_DEF);
      check(multidrop_en, 3'h0);
      rx_byte(0, 8'hA5, BIT_DIV_DEF, 1'h0);
      cfg(16'h0008, 1'h1, 7'h00, SRC_PRIMARY, 9'h002, 2'h1, 1'h0);
      check(multidrop_node_id, 7'h01);
      check(multidrop_en, 3'h1);
      for (int i = 0; i < 9; i++)
         rx_byte(i % 3, xs(), 8, 1'h0);
      rx_byte(2, 8'h3C, 8, 1'h1);
      fieldbus_fitted = 1'h1;
      rx_byte(1, 8'h5A, 8, 1'h0);
      for (int s = 0; s < 4; s++) begin
         cfg(16'h0008, 1'h0, 7'h7F, psp_src_type'(s), 9'h000, 2'h3, 1'h0);
         for (int k = 0; k < 8; k++) begin
            cmd_is_operation = k[0];
            port_choice_closed = k[1];
            fieldbus_fitted = k[2];
            tick(2);
            cmd_done = 3'h7;
            #5;
            eff = k[1] ? 0 : s;
            for (int p = 0; p < 3; p++)
               ex[p] = !(p == 1 && k[2]) && (!k[0] || eff == p + 1);
            check(cmd_accept, ex);
            check(op_source_active, eff);
            tick(1);
            cmd_done = 3'h0;
         end
      end
      port_choice_closed = 1'h0;
      fieldbus_fitted = 1'h0;
      check(multidrop_node_id, 7'h7F);
      tick(RESP + 2);
      cmd_done = 3'h1;
      tick(1);
      cmd_done = 3'h0;
      for (n = 0; tx_ready[0] !== 1'h1 && n < 100; n++)
         tick(1);
      check(n, RESP);
      for (int p = 0; p < 3; p++) begin
         d = xs();
         fork
            u_host.recv_char(p, 8, got, ok);
            begin
               tx_data[8*p+:8] = d;
               tx_valid[p] = 1'h1;
               for (n = 0; tx_ready[p] !== 1'h1 && n < 50; n++)
                  tick(1);
               tick(1);
               tx_valid[p] = 1'h0;
               check(tx_drive_oe[p], 1'h1);
            end
         join
         check({ok, got}, {1'h1, d});
         tick(10);
         check(tx_drive_oe, 3'h4);
      end
      cfg(16'h0008, 1'h0, 7'h05, SRC_PRIMARY, 9'h002, 2'h0, 1'h1);
      check(tx_drive_oe, 3'h5);
      pump_running = 1'h1;
      for (int i = 0; i < 4; i++)
         rx_byte(0, xs(), 8, 1'h0);
      check(comm_fail, 1'h0);
      for (n = 0; comm_fail !== 1'h1 && n < 1000; n++)
         tick(1);
      if (n == 1000)
         fail_out;
      n = cyc - last_rx;
      check(n >= 2 * MIN - 1 && n <= 2 * MIN + 3, 1'h1);
      check(pump_stop_req, 1'h1);
      pump_running = 1'h0;
      comm_fail_clear = 1'h1;
      tick(1);
      comm_fail_clear = 1'h0;
      tick(1);
      check(comm_fail, 1'h0);
      cfg(16'h0008, 1'h0, 7'h05, SRC_PRIMARY, 9'h000, 2'h0, 1'h0);
      pump_running = 1'h1;
      tick(600);
      check(comm_fail, 1'h0);
      results;
   end
endmodule
